// [core/sdram_address_decode.sv]
// Address and bank interpretation of a four-bank synchronous DRAM
//
// How it works
// - The two bank inputs pick the bank for activate, read, write and single-bank precharge.
// - An activate captures all thirteen address lines as the row of the chosen bank.
// - Read and write take the column from bits 9..0, plus 11 and 12 on x4 and 11 on x8.
// - On read and write bit 10 is not column but asks for auto precharge.
// - On precharge bit 10 high precharges all banks, low only the chosen bank.
// - A load mode register command takes its op-code from the address lines.
// - The data bus is sixteen, eight or four lines wide; upper lines are dead when narrower.
// - Every input is registered on the rising clock edge.
// - The command is decoded from chip select and the three strobes, and steers decoding.
`timescale 1ns/1ns
`default_nettype none
module sdram_address_decode #(
   parameter sdram_addr_pkg::org_t ORG = sdram_addr_pkg::ORG_X16
) (
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   input  wire sdram_addr_pkg::cmd_pins_t           cmdPins,
   input  wire logic [sdram_addr_pkg::BANK_W-1:0]   bankSel,
   input  wire logic [sdram_addr_pkg::ADDR_W-1:0]   addr,
   input  wire logic [sdram_addr_pkg::DQ_W-1:0]     dqIn,
   input  wire logic [sdram_addr_pkg::DQ_W-1:0]     dqWrite,
   input  wire logic                                dqDrive,
   output var  sdram_addr_pkg::decode_t             decoded,
   output var  logic [sdram_addr_pkg::ADDR_W-1:0]   openRow,
   output var  logic [sdram_addr_pkg::DQ_W-1:0]     dqOut,
   output var  logic [sdram_addr_pkg::DQ_W-1:0]     dqOe,
   output var  logic [sdram_addr_pkg::DQ_W-1:0]     dqData
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Command truth from active-low pins
   function automatic sdram_addr_pkg::cmd_t decode_cmd(
      input sdram_addr_pkg::cmd_pins_t p
   );
      sdram_addr_pkg::cmd_t c;
      c = sdram_addr_pkg::CMD_OTHER;
      if (p.csN)
         c = sdram_addr_pkg::CMD_NOP;
      else begin
         case ({p.rasN, p.casN, p.weN})
            3'h7:    c = sdram_addr_pkg::CMD_NOP;
            3'h3:    c = sdram_addr_pkg::CMD_ACTIVE;
            3'h5:    c = sdram_addr_pkg::CMD_READ;
            3'h4:    c = sdram_addr_pkg::CMD_WRITE;
            3'h2:    c = sdram_addr_pkg::CMD_PRECHARGE;
            3'h0:    c = sdram_addr_pkg::CMD_LOAD_MODE;
            default: c = sdram_addr_pkg::CMD_OTHER;
         endcase
      end
      return c;
   endfunction : decode_cmd

   // Lane mask for the organisation
   function automatic logic [sdram_addr_pkg::DQ_W-1:0] lane_mask(
      input sdram_addr_pkg::org_t o
   );
      logic [sdram_addr_pkg::DQ_W-1:0] m;
      case (o)
         sdram_addr_pkg::ORG_X4:  m = 16'h000F;
         sdram_addr_pkg::ORG_X8:  m = 16'h00FF;
         default:                 m = 16'hFFFF;
      endcase
      return m;
   endfunction : lane_mask

   // ------------------------------------------------------------------
   // Input sampling, three stages for command, bank and address, two for data
   // ------------------------------------------------------------------
   sdram_addr_pkg::cmd_pins_t                cmdS1, cmdS2, cmdS3;
   logic [sdram_addr_pkg::BANK_W-1:0]        bankS1, bankS2, bankS3;
   logic [sdram_addr_pkg::ADDR_W-1:0]        addrS1, addrS2, addrS3;
   logic [sdram_addr_pkg::DQ_W-1:0]          dqS1, dqS2;

   // Command strobes, three stages, reset to deselect
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmdS1 <= '1;
         cmdS2 <= '1;
         cmdS3 <= '1;
      end else begin
         cmdS1 <= cmdPins;
         cmdS2 <= cmdS1;
         cmdS3 <= cmdS2;
      end
   end

   // Bank select, three stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bankS1 <= '0;
         bankS2 <= '0;
         bankS3 <= '0;
      end else begin
         bankS1 <= bankSel;
         bankS2 <= bankS1;
         bankS3 <= bankS2;
      end
   end

   // Address lines, three stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addrS1 <= '0;
         addrS2 <= '0;
         addrS3 <= '0;
      end else begin
         addrS1 <= addr;
         addrS2 <= addrS1;
         addrS3 <= addrS2;
      end
   end

   // Data pins, two stages; data may change every cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dqS1 <= '0;
         dqS2 <= '0;
      end else begin
         dqS1 <= dqIn;
         dqS2 <= dqS1;
      end
   end

   // Accept a command only when stages two and three agree
   wire stable = (cmdS2 == cmdS3) && (bankS2 == bankS3) && (addrS2 == addrS3);

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   sdram_addr_pkg::cmd_t prevCmd;
   wire sdram_addr_pkg::cmd_t rawCmd = decode_cmd(cmdS2);
   // Fire once per held command
   wire sdram_addr_pkg::cmd_t curCmd = (stable && rawCmd != prevCmd) ? rawCmd
                                       : sdram_addr_pkg::CMD_NOP;

   wire isActive = (curCmd == sdram_addr_pkg::CMD_ACTIVE);
   wire isRdWr   = (curCmd == sdram_addr_pkg::CMD_READ) ||
                   (curCmd == sdram_addr_pkg::CMD_WRITE);
   wire isPre    = (curCmd == sdram_addr_pkg::CMD_PRECHARGE);
   wire isLmr    = (curCmd == sdram_addr_pkg::CMD_LOAD_MODE);
   wire scopeBit = addrS2[sdram_addr_pkg::PRE_BIT];

   // Column per organisation, bit 10 excluded
   wire [sdram_addr_pkg::COL_W-1:0] colLow = {2'h0, addrS2[sdram_addr_pkg::COL_LO_W-1:0]};
   wire [sdram_addr_pkg::COL_W-1:0] colX8  = {1'h0, addrS2[sdram_addr_pkg::COL_B11],
                                              addrS2[sdram_addr_pkg::COL_LO_W-1:0]};
   wire [sdram_addr_pkg::COL_W-1:0] colX4  = {addrS2[sdram_addr_pkg::COL_B12],
                                              addrS2[sdram_addr_pkg::COL_B11],
                                              addrS2[sdram_addr_pkg::COL_LO_W-1:0]};
   wire [sdram_addr_pkg::COL_W-1:0] colSel =
      (ORG == sdram_addr_pkg::ORG_X4) ? colX4 :
      (ORG == sdram_addr_pkg::ORG_X8) ? colX8 : colLow;

   wire [sdram_addr_pkg::NBANKS-1:0] oneBank =
      sdram_addr_pkg::NBANKS'(1) << bankS2;
   wire [sdram_addr_pkg::NBANKS-1:0] preMask =
      !isPre   ? sdram_addr_pkg::MASK_NONE :
      scopeBit ? sdram_addr_pkg::MASK_ALL : oneBank;

   // Assemble result; unused fields forced to zero
   sdram_addr_pkg::decode_t next_decoded;
   always_comb begin
      next_decoded         = '0;
      next_decoded.cmd     = curCmd;
      next_decoded.bank    = (isActive || isRdWr || (isPre && !scopeBit))
                             ? bankS2 : '0;
      next_decoded.row     = isActive ? addrS2 : sdram_addr_pkg::ADDR_ZERO;
      next_decoded.col     = isRdWr ? colSel : sdram_addr_pkg::COL_ZERO;
      next_decoded.autoPre = isRdWr && scopeBit;
      next_decoded.preMask = preMask;
      next_decoded.opCode  = isLmr ? addrS2 : sdram_addr_pkg::ADDR_ZERO;
   end

   // ------------------------------------------------------------------
   // Open row per bank
   // ------------------------------------------------------------------
   sdram_row_store #(
      .DEPTH (sdram_addr_pkg::NBANKS),
      .AW    (sdram_addr_pkg::BANK_W),
      .DW    (sdram_addr_pkg::ADDR_W)
   ) u_rows (
      .clk    (clk),
      .rst_n  (rst_n),
      .wrEn   (isActive),
      .wrAddr (bankS2),
      .wrData (addrS2),
      .rdAddr (bankS2),
      .rdData (openRow)
   );

   // ------------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------------
   wire [sdram_addr_pkg::DQ_W-1:0] lanes = lane_mask(ORG);

   // Last accepted command and the decoded result
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prevCmd <= sdram_addr_pkg::CMD_NOP;
         decoded <= '0;
      end else begin
         prevCmd <= stable ? rawCmd : prevCmd;
         decoded <= next_decoded;
      end
   end

   // Data lanes, dead upper lines held low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dqOut  <= '0;
         dqOe   <= '0;
         dqData <= '0;
      end else begin
         dqOut  <= dqWrite & lanes;
         dqOe   <= dqDrive ? lanes : '0;
         dqData <= dqS2 & lanes;
      end
   end

endmodule : sdram_address_decode
`default_nettype wire

// [core/sdram_addr_pkg.sv]
// Package: constants and carrier types for the SDRAM address decode block
package sdram_addr_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int BANK_W  = 2;
   localparam int ADDR_W  = 13;
   localparam int COL_W   = 12;
   localparam int DQ_W    = 16;
   localparam int NBANKS  = 4;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int COL_LO_W   = 10;  // Low column bits 9..0
   localparam int PRE_BIT    = 10;  // Precharge scope / auto precharge
   localparam int COL_B11    = 11;
   localparam int COL_B12    = 12;

   // Organisation codes
   typedef enum logic [1:0] {
      ORG_X4  = 2'h0,
      ORG_X8  = 2'h1,
      ORG_X16 = 2'h2
   } org_t;

   // Decoded commands
   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_ACTIVE,
      CMD_READ,
      CMD_WRITE,
      CMD_PRECHARGE,
      CMD_LOAD_MODE,
      CMD_OTHER
   } cmd_t;

   // Command pins, active low
   typedef struct packed {
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
   } cmd_pins_t;

   // Interpreted address result
   typedef struct packed {
      cmd_t              cmd;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] row;
      logic [COL_W-1:0]  col;
      logic              autoPre;
      logic [NBANKS-1:0] preMask;
      logic [ADDR_W-1:0] opCode;
   } decode_t;

   localparam logic [COL_W-1:0]  COL_ZERO  = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 13'h0000;
   localparam logic [NBANKS-1:0] MASK_ALL  = 4'hF;
   localparam logic [NBANKS-1:0] MASK_NONE = 4'h0;

endpackage : sdram_addr_pkg

// [core/sdram_row_store.sv]
// Memory of the open row address per bank, registered read data
`timescale 1ns/1ns
`default_nettype none
module sdram_row_store #(
   parameter int DEPTH = 4,
   parameter int AW    = 2,
   parameter int DW    = 13
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   input  wire logic [AW-1:0] rdAddr,
   output var  logic [DW-1:0] rdData
);

   logic [DW-1:0] mem [DEPTH];

   // ------------------------------------------------------------------
   // Storage and registered read
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
         rdData <= '0;
      end else begin
         if (wrEn) mem[wrAddr] <= wrData;
         rdData <= mem[rdAddr];
      end
   end

endmodule : sdram_row_store
`default_nettype wire

// [test/sdram_address_decode_properties.sv]
// Checker of the decode outputs against the command and address pins
`timescale 1ns/1ns
`default_nettype none
module sdram_address_decode_properties #(
   parameter sdram_addr_pkg::org_t ORG = sdram_addr_pkg::ORG_X16
) (
   input wire logic                      clk,
   input wire logic                      rst_n,
   input wire sdram_addr_pkg::cmd_pins_t cmdPins,
   input wire logic [1:0]                bankSel,
   input wire logic [12:0]               addr,
   input wire sdram_addr_pkg::decode_t   decoded,
   input wire logic [15:0]               dqOut,
   input wire logic [15:0]               dqOe,
   input wire logic [15:0]               dqData
);
   // ----
   // Helpers
   // ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   localparam logic [15:0] LANES = ORG == sdram_addr_pkg::ORG_X4 ? 16'h000F :
                                   ORG == sdram_addr_pkg::ORG_X8 ? 16'h00FF : 16'hFFFF;
   localparam logic HAS11 = ORG != sdram_addr_pkg::ORG_X16;
   localparam logic HAS12 = ORG == sdram_addr_pkg::ORG_X4;
   wire logic isAct = decoded.cmd == sdram_addr_pkg::CMD_ACTIVE;
   wire logic isRw  = decoded.cmd inside {sdram_addr_pkg::CMD_READ, sdram_addr_pkg::CMD_WRITE};
   wire logic isPre = decoded.cmd == sdram_addr_pkg::CMD_PRECHARGE;
   wire logic isLmr = decoded.cmd == sdram_addr_pkg::CMD_LOAD_MODE;
   wire logic isNop = decoded.cmd == sdram_addr_pkg::CMD_NOP;
   // ----
   // Properties
   // ----
   bank_select_a: assert property (
      (isAct || isRw) |-> decoded.bank == $past(bankSel, 3)) else $error("bank mismatch");
   row_capture_a: assert property (
      isAct |-> $past(cmdPins, 3) == 4'h3 && decoded.row == $past(addr, 3))
      else $error("row mismatch");
   column_capture_a: assert property (
      isRw |-> decoded.col == {HAS12 & $past(addr[12], 3), HAS11 & $past(addr[11], 3),
      $past(addr[9:0], 3)}) else $error("column mismatch");
   auto_precharge_a: assert property (
      isRw |-> decoded.autoPre == $past(addr[10], 3)) else $error("auto precharge mismatch");
   precharge_scope_a: assert property (
      isPre |-> $past(cmdPins, 3) == 4'h2 && decoded.preMask ==
      ($past(addr[10], 3) ? 4'hF : 4'h1 << $past(bankSel, 3))) else $error("scope mismatch");
   op_code_a: assert property (
      isLmr |-> $past(cmdPins, 3) == 4'h0 && decoded.opCode == $past(addr, 3))
      else $error("op-code mismatch");
   lane_width_a: assert property (
      ((dqOut | dqOe | dqData) & ~LANES) == 16'h0000) else $error("dead lane active");
   chip_select_a: assert property (
      !isNop |-> !$past(cmdPins.csN, 3)) else $error("deselected command decoded");
   idle_fields_a: assert property (
      isNop |-> decoded.row == 13'h0000 && decoded.col == 12'h000 && decoded.opCode == 13'h0000)
      else $error("idle fields not zero");
endmodule : sdram_address_decode_properties
bind sdram_address_decode sdram_address_decode_properties #(.ORG(ORG)) chk (
   .clk(clk), .rst_n(rst_n), .cmdPins(cmdPins), .bankSel(bankSel), .addr(addr),
   .decoded(decoded), .dqOut(dqOut), .dqOe(dqOe), .dqData(dqData));
`default_nettype wire

// [test/sdram_ctrl_model.sv]
// Controller model driving commands and addresses into the decode block
`timescale 1ns/1ns
`default_nettype none
module sdram_ctrl_model (
   input  wire logic                      clk,
   output var  sdram_addr_pkg::cmd_pins_t cmdPins,
   output var  logic [1:0]                bankSel,
   output var  logic [12:0]               addr,
   output var  logic [15:0]               dqIn
);
   // Deselected and idle at start
   initial begin
      cmdPins = 4'hF;
      bankSel = 2'h0;
      addr    = 13'h0000;
   end
   // Released data lines start low and toggle every cycle
   initial begin
      dqIn = 16'h0000;
      forever @(negedge clk) dqIn <= ~dqIn;
   end
   // Command held four edges, then NOP with inverted address lines
   task automatic issue(input logic cs, input logic [2:0] c, input logic [1:0] b,
                        input logic [12:0] a);
      @(negedge clk);
      cmdPins <= {cs, c};
      bankSel <= b;
      addr    <= a;
      repeat (4) @(negedge clk);
      cmdPins <= 4'h7;
      bankSel <= ~b;
      addr    <= ~a;
      @(negedge clk);
   endtask : issue
endmodule : sdram_ctrl_model
`default_nettype wire

// [test/tb_sdram_address_decode.sv]
// Self-checking bench of the SDRAM address decode block
`timescale 1ns/1ns
`default_nettype none
module tb_sdram_address_decode;
   logic                      clk;
   logic                      rst_n;
   logic                      dqDrive;
   logic                      cs;
   logic [2:0]                code;
   logic [1:0]                b;
   logic [12:0]               a;
   logic [15:0]               dqWrite;
   logic [15:0]               dqIn;
   logic [1:0]                bankSel;
   logic [12:0]               addr;
   sdram_addr_pkg::cmd_pins_t cmdPins;
   sdram_addr_pkg::decode_t   decoded;
   sdram_addr_pkg::decode_t   decodedX4;
   sdram_addr_pkg::decode_t   decodedX16;
   logic [12:0]               openRow;
   logic [15:0]               dqOut;
   logic [15:0]               dqOe;
   logic [15:0]               dqData;
   logic [15:0]               dqOutX4;
   logic [15:0]               dqOutX16;
   logic [12:0]               addrQ[$];
   logic [12:0]               ea;
   integer                    rows [4];
   sdram_addr_pkg::decode_t   x;
   sdram_addr_pkg::decode_t   e;
   sdram_addr_pkg::decode_t   expQ[$];
   integer                    miscompares;
   integer                    samplesChecked;
   integer                    cycles;
   integer                    seed;
   // Device under test, x8 organisation, and its controller
   sdram_address_decode #(.ORG(sdram_addr_pkg::ORG_X8)) uut (
      .clk(clk), .rst_n(rst_n), .cmdPins(cmdPins), .bankSel(bankSel), .addr(addr),
      .dqIn(dqIn), .dqWrite(dqWrite), .dqDrive(dqDrive), .decoded(decoded),
      .openRow(openRow), .dqOut(dqOut), .dqOe(dqOe), .dqData(dqData));
   // The other two organisations see the same pins
   sdram_address_decode #(.ORG(sdram_addr_pkg::ORG_X4)) uutX4 (
      .clk(clk), .rst_n(rst_n), .cmdPins(cmdPins), .bankSel(bankSel), .addr(addr),
      .dqIn(dqIn), .dqWrite(dqWrite), .dqDrive(dqDrive), .decoded(decodedX4),
      .openRow(), .dqOut(dqOutX4), .dqOe(), .dqData());
   sdram_address_decode #(.ORG(sdram_addr_pkg::ORG_X16)) uutX16 (
      .clk(clk), .rst_n(rst_n), .cmdPins(cmdPins), .bankSel(bankSel), .addr(addr),
      .dqIn(dqIn), .dqWrite(dqWrite), .dqDrive(dqDrive), .decoded(decodedX16),
      .openRow(), .dqOut(dqOutX16), .dqOe(), .dqData());
   sdram_ctrl_model ctrl (
      .clk(clk), .cmdPins(cmdPins), .bankSel(bankSel), .addr(addr), .dqIn(dqIn));
   // ----
   // Clock, timeout, compare and verdict
   // ----
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         miscompares = miscompares + 1;
         print_verdict();
      end
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] ex);
      samplesChecked = samplesChecked + 1;
      if (seen !== ex) begin
         miscompares = miscompares + 1;
         $display("BAD %s expected %h seen %h", name, ex, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   // Each decoded command against the oldest expected one
   always @(negedge clk) begin
      if (rst_n && decoded.cmd !== sdram_addr_pkg::CMD_NOP) begin
         e = expQ.size() > 0 ? expQ.pop_front() : '0;
         ea = addrQ.size() > 0 ? addrQ.pop_front() : 13'h0000;
         check("cmd", 16'(decoded.cmd), 16'(e.cmd));
         check("cmdX4", 16'(decodedX4.cmd), 16'(e.cmd));
         check("cmdX16", 16'(decodedX16.cmd), 16'(e.cmd));
         if (e.cmd inside {sdram_addr_pkg::CMD_READ, sdram_addr_pkg::CMD_WRITE}) begin
            check("colX4", 16'(decodedX4.col), 16'({ea[12], ea[11], ea[9:0]}));
            check("colX16", 16'(decodedX16.col), 16'({2'h0, ea[9:0]}));
         end
         if (e.cmd inside {sdram_addr_pkg::CMD_ACTIVE, sdram_addr_pkg::CMD_READ,
                           sdram_addr_pkg::CMD_WRITE, sdram_addr_pkg::CMD_PRECHARGE})
            check("bank", 16'(decoded.bank), 16'(e.bank));
         check("row", 16'(decoded.row), 16'(e.row));
         check("col", 16'(decoded.col), 16'(e.col));
         check("autoPre", 16'(decoded.autoPre), 16'(e.autoPre));
         check("preMask", 16'(decoded.preMask), 16'(e.preMask));
         check("opCode", 16'(decoded.opCode), 16'(e.opCode));
      end
   end
   // ----
   // Every command code with random bank and address
   // ----
   initial begin
      seed = 39;
      miscompares = 0;
      samplesChecked = 0;
      cycles = 0;
      rows = '{default: 0};
      rst_n = 1'b0;
      dqWrite = 16'h0000;
      dqDrive = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 72; i++) begin
         // Mid-run reset clears the decode and the row memory
         if (i == 36) begin
            rst_n = 1'b0;
            @(negedge clk);
            check("rstRow", 16'(openRow), 16'h0000);
            check("rstCmd", 16'(decoded.cmd), 16'(sdram_addr_pkg::CMD_NOP));
            rows = '{default: 0};
            rst_n = 1'b1;
         end
         code = i[2:0];
         cs = (i % 9 == 8);
         b = 2'($random(seed));
         a = 13'($random(seed));
         x = '0;
         x.bank = b;
         case ({cs, code})
            4'h3: begin
               x.cmd = sdram_addr_pkg::CMD_ACTIVE;
               x.row = a;
            end
            4'h4, 4'h5: begin
               x.cmd = code[0] ? sdram_addr_pkg::CMD_READ : sdram_addr_pkg::CMD_WRITE;
               x.col = {1'b0, a[11], a[9:0]};
               x.autoPre = a[10];
            end
            4'h2: begin
               x.cmd = sdram_addr_pkg::CMD_PRECHARGE;
               x.preMask = a[10] ? 4'hF : 4'h1 << b;
               x.bank = a[10] ? 2'h0 : b;
            end
            4'h0: begin
               x.cmd = sdram_addr_pkg::CMD_LOAD_MODE;
               x.opCode = a;
            end
            4'h1, 4'h6: x.cmd = sdram_addr_pkg::CMD_OTHER;
            default: x.cmd = sdram_addr_pkg::CMD_NOP;
         endcase
         if (x.cmd != sdram_addr_pkg::CMD_NOP) begin
            expQ.push_back(x);
            addrQ.push_back(a);
         end
         if (x.cmd == sdram_addr_pkg::CMD_ACTIVE)
            rows[b] = a;
         ctrl.issue(cs, code, b, a);
         check("openRow", 16'(openRow), 16'(rows[b]));
         check("dqOut", dqOut, dqWrite & 16'h00FF);
         check("dqOutX4", dqOutX4, dqWrite & 16'h000F);
         check("dqOutX16", dqOutX16, dqWrite);
         check("dqOe", dqOe, dqDrive ? 16'h00FF : 16'h0000);
         check("dqData", dqData, dqIn & 16'h00FF);
         dqWrite = 16'($random(seed));
         dqDrive = 1'($random(seed));
      end
      repeat (8) @(negedge clk);
      check("pending", 16'(expQ.size()), 16'h0000);
      print_verdict();
   end
endmodule : tb_sdram_address_decode
`default_nettype wire
